// File: verilog/pmbus_config_command_set.v
/*
  Configuration command set of a power module behind a two-wire management
  bus slave: bus engine with optional checksum, register bank, nonvolatile
  shadow copies, write lock, alert gating, enable logic and output slewing.
  Assumes bus clock and data pins arrive unsynchronised and open drain;
  fault events and input voltage sense come from logic on clk.
*/
`timescale 1ns/1ns
`include "pmbus_consts.vh"

// Functional notes
// - on/off command resets to zero and alone does not enable output.
// - enable source config combines pin and command; default pin only, high.
// - fault clear zeroes fault status and releases the alert; no data.
// - write lock gates register writes and restores; default allows all.
// - both store commands copy storable settings into nonvolatile copies.
// - both restore commands reload storable settings from nonvolatile copies.
// - feature report reads a fixed capability byte and ignores writes.
// - alert mask blocks chosen status bits; default masks power good only.
// - output format reads a fixed exponent of minus nine.
// - output target slews toward the setpoint clamped at the upper limit.
// - upper limit restores from the scale ratio: 034d, 069a, 0c00.
// - output target slews toward the setpoint clamped at the lower limit.
// - lower limit restores from the scale ratio: 00b3, 0166, 02cc.
// - output moves toward a new setpoint at the programmed slew rate.
// - scale ratio feeds the control loop and defaults to one.
// - conversion starts only once input reaches the start threshold.
// - conversion stops once input falls to the stop threshold.
// - current sense offset is driven to the sense path; default zero.
// - checksum byte is optional; used only when host clocks it.
// - words go low byte first, each byte most significant bit first.
module pmbus_config_command_set
#(
  parameter [6:0] dev_addr = `DEV_ADDR_DEFAULT
)
(
  input wire clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  output reg alert_out,
  output reg alert_oe,
  input wire control_enable_pin,
  input wire [7:0] fault_event,
  input wire [15:0] vin_sense,
  output reg [7:0] fault_status,
  output reg conversion_enable,
  output reg [15:0] vout_target,
  output reg [15:0] sense_scaling_ratio,
  output reg [15:0] current_sense_offset
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_RX = 3'h1;
localparam [2:0] ST_RXACK = 3'h2;
localparam [2:0] ST_TX = 3'h3;
localparam [2:0] ST_TXACK = 3'h4;

////////////////////////////////////////////////////////////////////////////////
// helpers

function [7:0] crc8;
  input [7:0] c;
  input [7:0] d;
  integer i;
  reg [7:0] r;
  begin
    r = c ^ d;
    for (i = 0; i < 8; i = i + 1)
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    crc8 = r;
  end
endfunction

// data length of a command; 3 marks an unsupported code
function [1:0] cmd_len;
  input [7:0] c;
  begin
    case (c)
      `CMD_CLR_FAULT, `CMD_STORE_DEF, `CMD_RESTORE_DEF, `CMD_STORE_USR,
      `CMD_RESTORE_USR: cmd_len = 2'd0;
      `CMD_ON_OFF, `CMD_EN_SRC, `CMD_WR_LOCK, `CMD_FEATURE, `CMD_ALERT_MASK,
      `CMD_OUT_FMT: cmd_len = 2'd1;
      `CMD_SETPOINT, `CMD_UPPER, `CMD_SLEW, `CMD_SCALE, `CMD_LOWER,
      `CMD_VIN_START, `CMD_VIN_STOP, `CMD_CS_OFFSET: cmd_len = 2'd2;
      default: cmd_len = 2'd3;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: a level counts once stages two and three agree

reg [2:0] scl_s;
reg [2:0] sda_s;
reg [2:0] pin_s;
reg scl_f;
reg sda_f;
reg pin_f;
reg scl_d;
reg sda_d;

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    scl_s <= 3'h7;
    sda_s <= 3'h7;
    pin_s <= 3'h0;
    scl_f <= 1'b1;
    sda_f <= 1'b1;
    pin_f <= 1'b0;
    scl_d <= 1'b1;
    sda_d <= 1'b1;
  end
  else
  begin
    scl_s <= {scl_s[1:0], scl_in};
    sda_s <= {sda_s[1:0], sda_in};
    pin_s <= {pin_s[1:0], control_enable_pin};
    if (scl_s[1] == scl_s[2])
      scl_f <= scl_s[2];
    if (sda_s[1] == sda_s[2])
      sda_f <= sda_s[2];
    if (pin_s[1] == pin_s[2])
      pin_f <= pin_s[2];
    scl_d <= scl_f;
    sda_d <= sda_f;
  end
end

wire scl_rise = scl_f & ~scl_d;
wire scl_fall = ~scl_f & scl_d;
wire start_det = scl_f & scl_d & sda_d & ~sda_f;
wire stop_det = scl_f & scl_d & ~sda_d & sda_f;

////////////////////////////////////////////////////////////////////////////////
// register bank storage

reg [7:0] on_off;
reg [7:0] en_src;
reg [7:0] wr_lock;
reg [7:0] alert_mask;
reg [15:0] setpoint;
reg [15:0] upper;
reg [15:0] slew;
reg [15:0] lower;
reg [15:0] vin_start;
reg [15:0] vin_stop;
reg [7:0] nvm_en_src;
reg [7:0] nvm_wr_lock;
reg [7:0] nvm_alert_mask;
reg [15:0] nvm_setpoint;
reg [15:0] nvm_scale;
reg [15:0] nvm_vin_start;
reg [15:0] nvm_vin_stop;
reg [15:0] nvm_cs_offset;

////////////////////////////////////////////////////////////////////////////////
// bus engine

reg [2:0] state;
reg [3:0] bit_cnt;
reg [7:0] shreg;
reg [7:0] crc;
reg [7:0] cmd;
reg [7:0] data_lo;
reg [7:0] data_hi;
reg [1:0] byte_cnt;
reg [1:0] tx_idx;
reg is_addr;
reg have_cmd;
reg reading;
reg in_xfer;
reg [15:0] rd_val;

wire [1:0] len = cmd_len(cmd);

always @*
begin
  case (cmd)
    `CMD_ON_OFF: rd_val = {8'h00, on_off};
    `CMD_EN_SRC: rd_val = {8'h00, en_src};
    `CMD_WR_LOCK: rd_val = {8'h00, wr_lock};
    `CMD_FEATURE: rd_val = {8'h00, `VAL_FEATURE};
    `CMD_ALERT_MASK: rd_val = {8'h00, alert_mask};
    `CMD_OUT_FMT: rd_val = {8'h00, `VAL_OUT_FMT};
    `CMD_SETPOINT: rd_val = setpoint;
    `CMD_UPPER: rd_val = upper;
    `CMD_SLEW: rd_val = slew;
    `CMD_SCALE: rd_val = sense_scaling_ratio;
    `CMD_LOWER: rd_val = lower;
    `CMD_VIN_START: rd_val = vin_start;
    `CMD_VIN_STOP: rd_val = vin_stop;
    `CMD_CS_OFFSET: rd_val = current_sense_offset;
    default: rd_val = 16'hffff;
  endcase
end

// low byte first, then checksum, then idle ones
wire [7:0] tx_byte = (tx_idx < len) ? (tx_idx[0] ? rd_val[15:8] : rd_val[7:0])
  : ((tx_idx == len) ? crc : 8'hff);

// a write lands at stop with exact length, or one extra byte giving crc zero
wire len_ok = ({1'b0, byte_cnt} == {1'b0, len})
  | (({1'b0, byte_cnt} == ({1'b0, len} + 3'd1)) & (crc == 8'h00));
wire commit = stop_det & in_xfer & have_cmd & ~reading & len_ok;

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    state <= ST_IDLE;
    bit_cnt <= 4'h0;
    shreg <= 8'h00;
    crc <= 8'h00;
    cmd <= 8'h00;
    data_lo <= 8'h00;
    data_hi <= 8'h00;
    byte_cnt <= 2'd0;
    tx_idx <= 2'd0;
    is_addr <= 1'b0;
    have_cmd <= 1'b0;
    reading <= 1'b0;
    in_xfer <= 1'b0;
    sda_oe <= 1'b0;
    sda_out <= 1'b0;
  end
  else if (start_det)
  begin
    state <= ST_RX;
    bit_cnt <= 4'h0;
    is_addr <= 1'b1;
    in_xfer <= 1'b1;
    // a read reply always begins with its low byte, whatever the last read left
    tx_idx <= 2'd0;
    sda_oe <= 1'b0;
    if (!in_xfer)
    begin
      crc <= 8'h00;
      have_cmd <= 1'b0;
      byte_cnt <= 2'd0;
      reading <= 1'b0;
    end
  end
  else if (stop_det)
  begin
    state <= ST_IDLE;
    in_xfer <= 1'b0;
    have_cmd <= 1'b0;
    sda_oe <= 1'b0;
  end
  else
  begin
    case (state)
      ST_RX:
      begin
        if (scl_rise)
        begin
          shreg <= {shreg[6:0], sda_f};
          bit_cnt <= bit_cnt + 4'h1;
        end
        else if (scl_fall && bit_cnt == 4'h8)
        begin
          crc <= crc8(crc, shreg);
          if (is_addr)
          begin
            // a read needs a command from the write phase before it
            if (shreg[7:1] == dev_addr && (!shreg[0] || have_cmd))
            begin
              reading <= shreg[0];
              is_addr <= 1'b0;
              sda_oe <= 1'b1;
              state <= ST_RXACK;
            end
            else
            begin
              state <= ST_IDLE;
              in_xfer <= 1'b0;
              have_cmd <= 1'b0;
            end
          end
          else if (!have_cmd)
          begin
            if (cmd_len(shreg) != 2'd3)
            begin
              cmd <= shreg;
              have_cmd <= 1'b1;
              sda_oe <= 1'b1;
              state <= ST_RXACK;
            end
            else
            begin
              state <= ST_IDLE;
              in_xfer <= 1'b0;
            end
          end
          else
          begin
            if (byte_cnt == 2'd0)
              data_lo <= shreg;
            if (byte_cnt == 2'd1)
              data_hi <= shreg;
            if (byte_cnt != 2'd3)
              byte_cnt <= byte_cnt + 2'd1;
            sda_oe <= 1'b1;
            state <= ST_RXACK;
          end
        end
      end
      ST_RXACK:
      begin
        if (scl_fall)
        begin
          bit_cnt <= 4'h0;
          if (reading)
          begin
            shreg <= tx_byte;
            crc <= crc8(crc, tx_byte);
            sda_oe <= ~tx_byte[7];
            tx_idx <= 2'd1;
            state <= ST_TX;
          end
          else
          begin
            sda_oe <= 1'b0;
            state <= ST_RX;
          end
        end
      end
      ST_TX:
      begin
        if (scl_rise)
          bit_cnt <= bit_cnt + 4'h1;
        else if (scl_fall)
        begin
          if (bit_cnt == 4'h8)
          begin
            sda_oe <= 1'b0;
            state <= ST_TXACK;
          end
          else
          begin
            shreg <= {shreg[6:0], 1'b0};
            sda_oe <= ~shreg[6];
          end
        end
      end
      ST_TXACK:
      begin
        if (scl_rise)
        begin
          if (sda_f)
            state <= ST_IDLE;
          else
            bit_cnt <= 4'h9;
        end
        else if (scl_fall && bit_cnt == 4'h9)
        begin
          bit_cnt <= 4'h0;
          shreg <= tx_byte;
          crc <= crc8(crc, tx_byte);
          sda_oe <= ~tx_byte[7];
          if (tx_idx != 2'd3)
            tx_idx <= tx_idx + 2'd1;
          state <= ST_TX;
        end
      end
      default:
        sda_oe <= 1'b0;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// register writes, nonvolatile copies, fault status

wire [15:0] wdata = {data_hi, data_lo};
wire wr_ok = (cmd == `CMD_WR_LOCK) | (wr_lock == `WP_NONE)
  | ((wr_lock == `WP_ON_OFF) & (cmd == `CMD_ON_OFF))
  | ((wr_lock == `WP_VOUT) & ((cmd == `CMD_ON_OFF) | (cmd == `CMD_EN_SRC)
  | (cmd == `CMD_SETPOINT)));
wire do_wr = commit & wr_ok;
wire do_store = commit & ((cmd == `CMD_STORE_DEF) | (cmd == `CMD_STORE_USR));
wire do_restore = commit & (wr_lock == `WP_NONE)
  & ((cmd == `CMD_RESTORE_DEF) | (cmd == `CMD_RESTORE_USR));
wire do_clear = commit & (cmd == `CMD_CLR_FAULT);

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    on_off <= `RST_ON_OFF;
    en_src <= `RST_EN_SRC;
    wr_lock <= `RST_WR_LOCK;
    alert_mask <= `RST_ALERT_MASK;
    setpoint <= `RST_SETPOINT;
    upper <= `UPPER_ONE;
    slew <= `RST_SLEW;
    sense_scaling_ratio <= `SCALE_ONE;
    lower <= `LOWER_ONE;
    vin_start <= `RST_VIN_START;
    vin_stop <= `RST_VIN_STOP;
    current_sense_offset <= `RST_CS_OFFSET;
    nvm_en_src <= `RST_EN_SRC;
    nvm_wr_lock <= `RST_WR_LOCK;
    nvm_alert_mask <= `RST_ALERT_MASK;
    nvm_setpoint <= `RST_SETPOINT;
    nvm_scale <= `SCALE_ONE;
    nvm_vin_start <= `RST_VIN_START;
    nvm_vin_stop <= `RST_VIN_STOP;
    nvm_cs_offset <= `RST_CS_OFFSET;
    fault_status <= 8'h00;
    alert_out <= 1'b0;
    alert_oe <= 1'b0;
  end
  else
  begin
    if (do_wr)
    begin
      case (cmd)
        `CMD_ON_OFF: on_off <= data_lo;
        `CMD_EN_SRC: en_src <= data_lo;
        `CMD_WR_LOCK: wr_lock <= data_lo;
        `CMD_ALERT_MASK: alert_mask <= data_lo;
        `CMD_SETPOINT: setpoint <= wdata;
        `CMD_UPPER: upper <= wdata;
        `CMD_SLEW: slew <= wdata;
        `CMD_SCALE: sense_scaling_ratio <= wdata;
        `CMD_LOWER: lower <= wdata;
        `CMD_VIN_START: vin_start <= wdata;
        `CMD_VIN_STOP: vin_stop <= wdata;
        `CMD_CS_OFFSET: current_sense_offset <= wdata;
        default: on_off <= on_off;
      endcase
    end
    if (do_store)
    begin
      nvm_en_src <= en_src;
      nvm_wr_lock <= wr_lock;
      nvm_alert_mask <= alert_mask;
      nvm_setpoint <= setpoint;
      nvm_scale <= sense_scaling_ratio;
      nvm_vin_start <= vin_start;
      nvm_vin_stop <= vin_stop;
      nvm_cs_offset <= current_sense_offset;
    end
    if (do_restore)
    begin
      en_src <= nvm_en_src;
      wr_lock <= nvm_wr_lock;
      alert_mask <= nvm_alert_mask;
      setpoint <= nvm_setpoint;
      sense_scaling_ratio <= nvm_scale;
      vin_start <= nvm_vin_start;
      vin_stop <= nvm_vin_stop;
      current_sense_offset <= nvm_cs_offset;
      // limits follow the ratio being restored; unknown ratios get the ratio-one limits
      case (nvm_scale)
        `SCALE_HALF:
        begin
          upper <= `UPPER_HALF;
          lower <= `LOWER_HALF;
        end
        `SCALE_QUARTER:
        begin
          upper <= `UPPER_QUARTER;
          lower <= `LOWER_QUARTER;
        end
        default:
        begin
          upper <= `UPPER_ONE;
          lower <= `LOWER_ONE;
        end
      endcase
    end
    // a new event in the clearing cycle survives the clear
    fault_status <= (do_clear ? 8'h00 : fault_status) | fault_event;
    alert_oe <= |(fault_status & ~alert_mask) & ~do_clear;
    alert_out <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// enable logic and output slewing

reg vin_ok;
reg [15:0] slew_cnt;

wire pin_on = (pin_f == en_src[`EN_SRC_POL]);
wire run_req = ~en_src[`EN_SRC_PU]
  | ((~en_src[`EN_SRC_CMD] | on_off[`ON_OFF_RUN])
  & (~en_src[`EN_SRC_PIN] | pin_on));
wire [15:0] goal = (setpoint > upper) ? upper
  : ((setpoint < lower) ? lower : setpoint);
wire [10:0] rate_m = slew[10:0];
wire [31:0] slew_div = (rate_m == 11'h000) ? 32'h0 : (`SLEW_SCALE / rate_m);
wire [15:0] step_gap = slew_div[15:0];

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    vin_ok <= 1'b0;
    conversion_enable <= 1'b0;
    vout_target <= `RST_SETPOINT;
    slew_cnt <= 16'h0000;
  end
  else
  begin
    // thresholds compare mantissas; sense is assumed in the same exponent
    if (vin_sense[10:0] >= vin_start[10:0])
      vin_ok <= 1'b1;
    else if (vin_sense[10:0] <= vin_stop[10:0])
      vin_ok <= 1'b0;
    conversion_enable <= vin_ok & run_req;
    if (rate_m == 11'h000)
    begin
      vout_target <= goal;
      slew_cnt <= 16'h0000;
    end
    else if (vout_target == goal)
      slew_cnt <= 16'h0000;
    else if (slew_cnt >= step_gap)
    begin
      slew_cnt <= 16'h0000;
      if (vout_target < goal)
        vout_target <= vout_target + 16'h0001;
      else
        vout_target <= vout_target - 16'h0001;
    end
    else
      slew_cnt <= slew_cnt + 16'h0001;
  end
end

endmodule // pmbus_config_command_set

// File: verilog/pmbus_consts.vh
/*
  Constants for the power-module configuration command set: command codes,
  reset values, write-lock codes, limit restore values and timing figures.
  Assumes inclusion by bare name from the single design module.
*/
`ifndef PMBUS_CONSTS_VH
`define PMBUS_CONSTS_VH

// command codes
`define CMD_ON_OFF 8'h01
`define CMD_EN_SRC 8'h02
`define CMD_CLR_FAULT 8'h03
`define CMD_WR_LOCK 8'h10
`define CMD_STORE_DEF 8'h11
`define CMD_RESTORE_DEF 8'h12
`define CMD_STORE_USR 8'h15
`define CMD_RESTORE_USR 8'h16
`define CMD_FEATURE 8'h19
`define CMD_ALERT_MASK 8'h1b
`define CMD_OUT_FMT 8'h20
`define CMD_SETPOINT 8'h21
`define CMD_UPPER 8'h24
`define CMD_SLEW 8'h27
`define CMD_SCALE 8'h29
`define CMD_LOWER 8'h2b
`define CMD_VIN_START 8'h35
`define CMD_VIN_STOP 8'h36
`define CMD_CS_OFFSET 8'h39

// reset values
`define RST_ON_OFF 8'h00
`define RST_EN_SRC 8'h16
`define RST_WR_LOCK 8'h00
`define VAL_FEATURE 8'hb0
`define RST_ALERT_MASK 8'h08
`define VAL_OUT_FMT 8'h17
`define RST_SETPOINT 16'h0133
`define RST_SLEW 16'hd03c
`define RST_VIN_START 16'hf012
`define RST_VIN_STOP 16'hf010
`define RST_CS_OFFSET 16'he000

// scale ratio codes and the limits restored for each
`define SCALE_ONE 16'hf004
`define SCALE_HALF 16'hf002
`define SCALE_QUARTER 16'hf001
`define UPPER_ONE 16'h034d
`define UPPER_HALF 16'h069a
`define UPPER_QUARTER 16'h0c00
`define LOWER_ONE 16'h00b3
`define LOWER_HALF 16'h0166
`define LOWER_QUARTER 16'h02cc

// write-lock codes
`define WP_NONE 8'h00
`define WP_ONLY_LOCK 8'h80
`define WP_ON_OFF 8'h40
`define WP_VOUT 8'h20

// bus and enable-config field positions
`define DEV_ADDR_DEFAULT 7'h20
`define EN_SRC_PU 4
`define EN_SRC_CMD 3
`define EN_SRC_PIN 2
`define EN_SRC_POL 1
`define ON_OFF_RUN 7

// timing: output lsb in microvolts, clock period in ns, slew mantissa for 1
`define LSB_UV 1953
`define CLK_NS 100
`define SLEW_MANT_ONE 64
`define SLEW_SCALE ((`LSB_UV * `SLEW_MANT_ONE) / `CLK_NS)

`endif

// File: tb/pmbus_cmd_asserts.sv
/*
  Checker for the command set block: bus pin timing, alert, slewing, enable.
  Assumes default limits, thresholds, mask, slew rate and enable config.
*/
`timescale 1ns/1ns
module pmbus_cmd_asserts
(
  input wire clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  input wire sda_oe,
  input wire alert_oe,
  input wire control_enable_pin,
  input wire [7:0] fault_event,
  input wire [15:0] vin_sense,
  input wire [7:0] fault_status,
  input wire conversion_enable,
  input wire [15:0] vout_target,
  input wire [15:0] sense_scaling_ratio,
  input wire [15:0] current_sense_offset
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_alert_quiet: assert property ((fault_status & 8'hf7) == 8'h00 |=> !alert_oe)
    else $error("alert held with no unmasked fault");
  a_alert_raise: assert property ($rose(|(fault_status & 8'hf7)) |=> alert_oe)
    else $error("unmasked fault did not raise alert");
  a_fault_sticky: assert property (fault_event != 8'h00 |=>
    (fault_status & $past(fault_event)) == $past(fault_event))
    else $error("fault event lost");
  a_slew_step: assert property (!$stable(vout_target) |->
    vout_target == $past(vout_target) + 16'd1 || vout_target == $past(vout_target) - 16'd1)
    else $error("target jumped more than one count");
  a_slew_gap: assert property (!$stable(vout_target) |=> $stable(vout_target) [*8])
    else $error("target stepped faster than the slew rate");
  a_conv_stop: assert property (conversion_enable && vin_sense[10:0] <= 11'h010
    |-> ##[1:4] !conversion_enable)
    else $error("conversion kept on below stop threshold");
  a_conv_pin: assert property ($fell(control_enable_pin) |-> ##[1:6] !conversion_enable)
    else $error("conversion kept on with control pin low");
  a_cfg_at_idle: assert property (
    !$stable(sense_scaling_ratio) || !$stable(current_sense_offset) |-> scl_in && sda_in)
    else $error("setting changed outside a stop");
  a_sda_change: assert property (!$stable(sda_oe) |-> !scl_in)
    else $error("data line moved while bus clock high");
endmodule // pmbus_cmd_asserts

bind pmbus_config_command_set pmbus_cmd_asserts pmbus_cmd_asserts_inst
(
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
  .alert_oe(alert_oe), .control_enable_pin(control_enable_pin), .fault_event(fault_event),
  .vin_sense(vin_sense), .fault_status(fault_status), .conversion_enable(conversion_enable),
  .vout_target(vout_target), .sense_scaling_ratio(sense_scaling_ratio),
  .current_sense_offset(current_sense_offset)
);

// File: tb/bus_host.sv
/*
  Bus master model: drives the bus clock, pulls the data line open drain.
  Assumes a pull-up on the data line; the clock stands high between frames.
*/
`timescale 1ns/1ns
module bus_host
(
  output logic scl,
  output logic sda_pull,
  input wire logic sda_line
);
  // phases of 330 ns keep each clock level above five system clocks
  localparam int q = 330;
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic start_cond();
    #q;
    sda_pull = 1'b0;
    #q;
    scl = 1'b1;
    #q;
    sda_pull = 1'b1;
    #q;
    scl = 1'b0;
  endtask
  task automatic stop_cond();
    #q;
    sda_pull = 1'b1;
    #q;
    scl = 1'b1;
    #q;
    sda_pull = 1'b0;
    #(4 * q);
  endtask
  task automatic bit_cycle(input logic b, output logic r);
    #q;
    sda_pull = ~b;
    #q;
    scl = 1'b1;
    #q;
    r = sda_line;
    #q;
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
    output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_cycle(tx[i], rx[i]);
    bit_cycle(ack_in, ack);
  endtask
endmodule // bus_host

// File: tb/testbench.sv
/*
  Self-checking bench: defaults, read-only places, slewing, clamps, lock,
  store and restore, faults and enable. Assumes the host model and checker.
*/
`timescale 1ns/1ns
module testbench;
  logic clk, rst, control_enable_pin, cmd_ack;
  logic [7:0] fault_event;
  logic [15:0] vin_sense, seed, sp, v;
  wire scl, sda_pull, sda_out, sda_oe, alert_out, alert_oe, conversion_enable;
  wire [7:0] fault_status;
  wire [15:0] vout_target, sense_scaling_ratio, current_sense_offset;
  // pull-up on the data line
  wire sda_line = ~(sda_pull | (sda_oe & ~sda_out));
  int fails = 0;
  int checked = 0;
  logic [7:0] codes [14] = '{8'h01, 8'h02, 8'h10, 8'h19, 8'h1b, 8'h20, 8'h21, 8'h24, 8'h27,
    8'h29, 8'h2b, 8'h35, 8'h36, 8'h39};
  logic [15:0] resets [14] = '{16'h0000, 16'h0016, 16'h0000, 16'h00b0, 16'h0008, 16'h0017,
    16'h0133, 16'h034d, 16'hd03c, 16'hf004, 16'h00b3, 16'hf012, 16'hf010, 16'he000};
  logic [15:0] ratio [3] = '{16'hf002, 16'hf001, 16'hf004};
  logic [15:0] upper [3] = '{16'h069a, 16'h0c00, 16'h034d};
  logic [15:0] lower [3] = '{16'h0166, 16'h02cc, 16'h00b3};
  logic [15:0] vin_tab [5] = '{16'hf014, 16'hf010, 16'hf011, 16'hf014, 16'hf014};
  logic [4:0] pin_tab = 5'b01111;
  logic [4:0] on_tab = 5'b01001;

  pmbus_config_command_set pmbus_config_command_set_inst
  (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe),
    .control_enable_pin(control_enable_pin), .fault_event(fault_event),
    .vin_sense(vin_sense), .fault_status(fault_status), .conversion_enable(conversion_enable),
    .vout_target(vout_target), .sense_scaling_ratio(sense_scaling_ratio),
    .current_sense_offset(current_sense_offset)
  );
  bus_host bus_host_inst (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////
  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] x;
    x = s ^ (s << 7);
    x = x ^ (x >> 9);
    return x ^ (x << 8);
  endfunction
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    repeat (8) x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
    return x;
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic send(input logic [7:0] b, inout logic [7:0] c, output logic a);
    logic [7:0] rx;
    bus_host_inst.xfer(b, 1'b1, rx, a);
    c = crc8(c, b);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n, input int pec);
    logic [7:0] c;
    logic a;
    c = 8'h00;
    bus_host_inst.start_cond();
    send(8'h40, c, a);
    send(cmd, c, cmd_ack);
    for (int i = 0; i < n; i++)
      send(d[8*i +: 8], c, a);
    // pec 2 flips a bit so the device has to discard the frame
    if (pec > 0)
      send(c ^ {7'h00, pec == 2}, c, a);
    bus_host_inst.stop_cond();
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [15:0] val);
    logic [7:0] c, rx;
    logic a;
    c = 8'h00;
    val = 16'h0000;
    bus_host_inst.start_cond();
    send(8'h40, c, a);
    send(cmd, c, a);
    bus_host_inst.start_cond();
    send(8'h41, c, a);
    for (int i = 0; i < ((cmd >= 8'h21) ? 2 : 1); i++)
    begin
      bus_host_inst.xfer(8'hff, 1'b0, rx, a);
      val[8*i +: 8] = rx;
      c = crc8(c, rx);
    end
    bus_host_inst.xfer(8'hff, 1'b1, rx, a);
    cmp({8'h00, rx}, {8'h00, c});
    bus_host_inst.stop_cond();
  endtask
  task automatic settle(input logic [15:0] exp);
    for (int i = 0; i < 5000 && vout_target !== exp; i++)
      @(posedge clk);
    cmp(vout_target, exp);
  endtask
  ////////////////////////////////////////
  initial
  begin
    rst <= 1'b1;
    control_enable_pin <= 1'b0;
    fault_event <= 8'h00;
    vin_sense <= 16'hf000;
    seed = 16'd56;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    cmp(sense_scaling_ratio, 16'hf004);
    cmp(current_sense_offset, 16'he000);
    for (int i = 0; i < 14; i++)
    begin
      rd(codes[i], v);
      cmp(v, resets[i]);
    end
    wr(8'h19, 16'h0055, 1, 0);
    wr(8'h20, 16'h0055, 1, 0);
    rd(8'h19, v);
    cmp(v, 16'h00b0);
    rd(8'h20, v);
    cmp(v, 16'h0017);
    wr(8'h05, 16'h0055, 1, 0);
    cmp({15'h0000, cmd_ack}, 16'h0001);
    $display("defaults done");
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk) control_enable_pin <= pin_tab[i];
      vin_sense <= vin_tab[i];
      repeat (20) @(posedge clk);
      cmp({15'h0000, conversion_enable}, {15'h0000, on_tab[i]});
    end
    $display("enable done");
    seed = xs(seed);
    sp = 16'h0100 + {9'h000, seed[6:0]};
    wr(8'h21, sp, 2, 1);
    settle(sp);
    wr(8'h21, sp + 16'h0020, 2, 2);
    rd(8'h21, v);
    cmp(v, sp);
    wr(8'h24, sp + 16'h0010, 2, 0);
    wr(8'h21, 16'h0400, 2, 0);
    settle(sp + 16'h0010);
    wr(8'h2b, sp - 16'h0010, 2, 0);
    wr(8'h21, 16'h0000, 2, 0);
    settle(sp - 16'h0010);
    $display("setpoint done");
    seed = xs(seed);
    wr(8'h39, seed, 2, 0);
    cmp(current_sense_offset, seed);
    wr(8'h10, 16'h0080, 1, 0);
    wr(8'h39, ~seed, 2, 0);
    cmp(current_sense_offset, seed);
    wr(8'h12, 16'h0000, 0, 0);
    cmp(current_sense_offset, seed);
    wr(8'h10, 16'h0000, 1, 0);
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h29, ratio[k], 2, 0);
      wr(k[0] ? 8'h15 : 8'h11, 16'h0000, 0, 0);
      wr(8'h29, ratio[(k + 1) % 3], 2, 0);
      wr(k[0] ? 8'h16 : 8'h12, 16'h0000, 0, 0);
      cmp(sense_scaling_ratio, ratio[k]);
      rd(8'h24, v);
      cmp(v, upper[k]);
      rd(8'h2b, v);
      cmp(v, lower[k]);
    end
    $display("lock and memory done");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk) fault_event <= 8'h01 << i;
      @(posedge clk) fault_event <= 8'h00;
      repeat (3) @(posedge clk);
      cmp({8'h00, fault_status}, 16'h0001 << i);
      cmp({15'h0000, alert_oe}, {15'h0000, i != 3});
      wr(8'h03, 16'h0000, 0, 0);
      cmp({8'h00, fault_status}, 16'h0000);
      cmp({15'h0000, alert_oe}, 16'h0000);
      cmp({15'h0000, alert_out}, 16'h0000);
    end
    $display("faults done");
    final_report();
  end
  // the whole sequence needs about 31k cycles
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule // testbench
